// >>> hdl/pamux_port_low.sv
// Low-pin function mux of the general-purpose port, with AHB-Lite registers.
// Assumes a single AHB-Lite slave position; hreadyout is the bus hready.
// Assumes the peripheral compare and latch outputs run on hclk.
//
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`include "pamux_defs.svh"
`default_nettype none

module pamux_port_low (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire pamux_pkg::pamux_pins_s pin_in,
    output pamux_pkg::pamux_pins_s pin_out,
    output pamux_pkg::pamux_pins_s pin_oe,
    input wire pamux_pkg::pamux_periph_s periph,
    output pamux_pkg::pamux_route_s route
);
    import pamux_pkg::*;

    logic [`PAMUX_NPINS-1:0] port_output_latch_q;
    logic [`PAMUX_NPINS-1:0] pin_direction_bit_q;
    logic [`PAMUX_NANA-1:0] analog_select_bit_q;
    logic [2:0] ctrl_q;
    logic [`PAMUX_NPINS-1:0] port_input_value;
    logic [`PAMUX_NPINS-1:0] analog_select_bit_full;
    logic [`PAMUX_NPINS-1:0] force_off;
    logic [`PAMUX_NPINS-1:0] out_value;
    logic [`PAMUX_NPINS-1:0] analog_on;
    logic dac_en;
    logic capture_compare_unit_five_en;
    logic srq_en;
    logic wr_pend_q;
    logic [`PAMUX_AW-1:0] wr_addr_q;
    logic [`PAMUX_NPINS-1:0] cell_out;
    logic [`PAMUX_NPINS-1:0] cell_oe;
    logic take;
    logic [`PAMUX_AW-1:0] a_addr;

    assign dac_en = ctrl_q[`PAMUX_CTRL_DAC];
    assign capture_compare_unit_five_en = ctrl_q[`PAMUX_CTRL_CAPTURE_COMPARE_UNIT_FIVE];
    assign srq_en = ctrl_q[`PAMUX_CTRL_SRQ];

    // ======================================================================
    // AHB-Lite slave. Zero wait states and always OKAY.
    assign hreadyout = 1'b1;
    assign hresp = `PAMUX_HRESP_OKAY;
    assign take = hsel & hready & htrans[`PAMUX_HTRANS_NONSEQ_BIT];
    assign a_addr = haddr[`PAMUX_AW-1:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
        end else if (hready) begin
            wr_pend_q <= take & hwrite;
            wr_addr_q <= a_addr;
        end
    end

    // ======================================================================
    // Software-visible controls, written in the data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_output_latch_q <= `PAMUX_RST_LATCH;
        end else if (wr_pend_q && wr_addr_q == `PAMUX_OFS_LATCH) begin
            port_output_latch_q <= hwdata[`PAMUX_NPINS-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_direction_bit_q <= `PAMUX_RST_DIR;
        end else if (wr_pend_q && wr_addr_q == `PAMUX_OFS_DIR) begin
            pin_direction_bit_q <= hwdata[`PAMUX_NPINS-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            analog_select_bit_q <= `PAMUX_RST_ANALOG_SELECT_BIT;
        end else if (wr_pend_q && wr_addr_q == `PAMUX_OFS_ANALOG_SELECT_BIT) begin
            analog_select_bit_q <= hwdata[`PAMUX_NANA-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= `PAMUX_RST_CTRL;
        end else if (wr_pend_q && wr_addr_q == `PAMUX_OFS_CTRL) begin
            ctrl_q <= hwdata[2:0];
        end
    end

    // ======================================================================
    // Read data. A read right after a write sees the old register contents,
    // which the data phase order of AHB-Lite makes legal and keeps it simple.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (take && !hwrite) begin
            case (a_addr)
                `PAMUX_OFS_LATCH: begin
                    hrdata <= {27'h0000000, port_output_latch_q};
                end
                `PAMUX_OFS_DIR: begin
                    hrdata <= {27'h0000000, pin_direction_bit_q};
                end
                `PAMUX_OFS_ANALOG_SELECT_BIT: begin
                    hrdata <= {28'h0000000, analog_select_bit_q};
                end
                `PAMUX_OFS_INPUT: begin
                    hrdata <= {27'h0000000, port_input_value};
                end
                `PAMUX_OFS_CTRL: begin
                    hrdata <= {29'h00000000, ctrl_q};
                end
                `PAMUX_OFS_ROUTE: begin
                    hrdata <= {21'h000000, route};
                end
                default: begin
                    hrdata <= 32'h00000000;
                end
            endcase
        end
    end

    // ======================================================================
    // Per-pin controls. Pin four has no analog select.
    assign analog_select_bit_full = {1'b0, analog_select_bit_q};
    assign force_off = {2'b00, dac_en, 2'b00};

    always_comb begin
        out_value = port_output_latch_q;
        if (srq_en) begin
            out_value[`PAMUX_PIN4] = periph.sr_latch_true_output;
        end else if (capture_compare_unit_five_en) begin
            out_value[`PAMUX_PIN4] = periph.capture_compare_unit_five;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `PAMUX_NPINS; gi = gi + 1) begin : g_pin
            pamux_pin_cell u_cell (
                .hclk(hclk),
                .hresetn(hresetn),
                .pin_level(pin_in.level[gi]),
                .out_value(out_value[gi]),
                .pin_direction_bit(pin_direction_bit_q[gi]),
                .analog_select_bit(analog_select_bit_full[gi]),
                .force_off(force_off[gi]),
                .pin_out(cell_out[gi]),
                .pin_oe(cell_oe[gi]),
                .port_input_value(port_input_value[gi])
            );
        end
    endgenerate

    // Each output struct gets one driver, not one per pin cell.
    assign pin_out.level = cell_out;
    assign pin_oe.level = cell_oe;

    // ======================================================================
    // Analog routing. A switch closes only with the pin an input and in analog mode,
    // save the DAC output, which closes with the DAC enable and pin two's analog select
    // and whose enable forces that pin's driver off, so a driven digital level never reaches a converter.
    assign analog_on = pin_direction_bit_q & analog_select_bit_full;

    always_comb begin
        route.comparator_shared_inv_in_zero = analog_on[`PAMUX_PIN0];
        route.analog_channel_zero = analog_on[`PAMUX_PIN0];
        route.comparator_shared_inv_in_one = analog_on[`PAMUX_PIN1];
        route.analog_channel_one = analog_on[`PAMUX_PIN1];
        route.comparator_two_noninv_in = analog_on[`PAMUX_PIN2];
        route.analog_channel_two = analog_on[`PAMUX_PIN2];
        route.adc_ref_low_in = analog_on[`PAMUX_PIN2];
        route.comparator_one_noninv_in = analog_on[`PAMUX_PIN3];
        route.analog_channel_three = analog_on[`PAMUX_PIN3];
        route.adc_ref_high_in = analog_on[`PAMUX_PIN3];
        route.dac_output_function = dac_en &
            analog_select_bit_q[`PAMUX_PIN2];
    end

endmodule

`default_nettype wire

// >>> hdl/pamux_defs.svh
// Constants for the low-pin function mux of the general-purpose port.
// Assumes inclusion by bare name from the package and the design files.
`ifndef PAMUX_DEFS_SVH
`define PAMUX_DEFS_SVH

// ==========================================================================
// Pin counts and widths
`define PAMUX_NPINS 5
`define PAMUX_NANA 4
`define PAMUX_AW 8

// ==========================================================================
// Register byte offsets
`define PAMUX_OFS_LATCH 8'h00
`define PAMUX_OFS_DIR 8'h04
`define PAMUX_OFS_ANALOG_SELECT_BIT 8'h08
`define PAMUX_OFS_INPUT 8'h0C
`define PAMUX_OFS_CTRL 8'h10
`define PAMUX_OFS_ROUTE 8'h14

// ==========================================================================
// Reset values
`define PAMUX_RST_LATCH 5'h00
`define PAMUX_RST_DIR 5'h1F
`define PAMUX_RST_ANALOG_SELECT_BIT 4'hF
`define PAMUX_RST_CTRL 3'h0

// ==========================================================================
// Control register fields
`define PAMUX_CTRL_DAC 0
`define PAMUX_CTRL_CAPTURE_COMPARE_UNIT_FIVE 1
`define PAMUX_CTRL_SRQ 2

// ==========================================================================
// Pin indices
`define PAMUX_PIN0 0
`define PAMUX_PIN1 1
`define PAMUX_PIN2 2
`define PAMUX_PIN3 3
`define PAMUX_PIN4 4

// ==========================================================================
// AHB-Lite encodings
`define PAMUX_HTRANS_NONSEQ_BIT 1
`define PAMUX_HRESP_OKAY 1'h0

`endif

// >>> hdl/pamux_pkg.sv
// Types shared by the low-pin function mux and its pin cell.
// Assumes pamux_defs.svh is on the include path.
`include "pamux_defs.svh"
`default_nettype none

package pamux_pkg;

    // ======================================================================
    // Pin group carried between the port and the board.
    typedef struct packed {
        logic [`PAMUX_NPINS-1:0] level;
    } pamux_pins_s;

    // ======================================================================
    // Analog route enables, one level per switch toward a peripheral.
    typedef struct packed {
        logic comparator_shared_inv_in_zero;
        logic comparator_shared_inv_in_one;
        logic comparator_two_noninv_in;
        logic comparator_one_noninv_in;
        logic analog_channel_zero;
        logic analog_channel_one;
        logic analog_channel_two;
        logic analog_channel_three;
        logic adc_ref_low_in;
        logic adc_ref_high_in;
        logic dac_output_function;
    } pamux_route_s;

    // ======================================================================
    // Peripheral digital outputs that may take pin four.
    typedef struct packed {
        logic capture_compare_unit_five;
        logic sr_latch_true_output;
    } pamux_periph_s;

endpackage

`default_nettype wire

// >>> hdl/pamux_pin_cell.sv
// One port pin: output driver choice, enable and the digital input path.
// Assumes the raw pin level is asynchronous to hclk.
`include "pamux_defs.svh"
`default_nettype none

module pamux_pin_cell (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic pin_level,
    input wire logic out_value,
    input wire logic pin_direction_bit,
    input wire logic analog_select_bit,
    input wire logic force_off,
    output logic pin_out,
    output logic pin_oe,
    output logic port_input_value
);

    logic sync1_q;
    logic sync2_q;

    // ======================================================================
    // Input synchroniser.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= pin_level;
            sync2_q <= sync1_q;
        end
    end

    // ======================================================================
    // Driver. The analog select never touches the driven value.
    assign pin_out = out_value;
    assign pin_oe = ~pin_direction_bit & ~force_off;

    // The input buffer is off under analog select or a forced-off path, so
    // the register bit reads zero rather than a floating analog level.
    assign port_input_value = sync2_q & ~analog_select_bit
        & ~force_off;

endmodule

`default_nettype wire

// >>> bench/pamux_port_low_asserts.sv
// Checker for the low-pin function mux, bound onto its top module.
// Assumes the slave answers every transfer at once with OKAY.
`default_nettype none
module pamux_port_low_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire pamux_pkg::pamux_pins_s pin_oe,
    input wire pamux_pkg::pamux_route_s route
);
    import pamux_pkg::*;
    // ========================================
    // Transfers taken by the slave
    logic take;
    assign take = hsel && hready && htrans[1];
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ========================================
    // Properties
    inv_zero_a: assert property (route.comparator_shared_inv_in_zero ==
        route.analog_channel_zero) else $error("inv zero route");
    inv_one_a: assert property (route.comparator_shared_inv_in_one ==
        route.analog_channel_one) else $error("inv one route");
    pin_two_a: assert property (route.comparator_two_noninv_in ==
        route.adc_ref_low_in && route.adc_ref_low_in ==
        route.analog_channel_two) else $error("pin two route");
    pin_three_a: assert property (route.comparator_one_noninv_in ==
        route.adc_ref_high_in && route.adc_ref_high_in ==
        route.analog_channel_three) else $error("pin three");
    dac_oe_a: assert property (route.dac_output_function |->
        !pin_oe.level[2]) else $error("pin two driven");
    route_oe_a: assert property (route.analog_channel_zero |->
        !pin_oe.level[0]) else $error("pin zero driven");
    ana_read_a: assert property (take && !hwrite && haddr[7:0] == 8'h0C
        && route.analog_channel_zero |=> hrdata[0] == 1'b0)
        else $error("analog pin read high");
    oe_write_a: assert property (!$stable(pin_oe) |->
        $past(take && hwrite, 2)) else $error("enable moved");
    read_top_a: assert property (take && !hwrite |=>
        hrdata[31:11] == 21'h000000) else $error("upper bits set");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready");
endmodule
bind pamux_port_low pamux_port_low_chk u_chk (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pin_oe(pin_oe), .route(route));
`default_nettype wire

// >>> bench/pamux_board.sv
// Board model: sets the level of every pin the port has released.
// Assumes the bench changes ext often, so no stale level lingers.
`default_nettype none
module pamux_board (
    input wire pamux_pkg::pamux_pins_s pin_out,
    input wire pamux_pkg::pamux_pins_s pin_oe,
    input wire pamux_pkg::pamux_pins_s ext,
    output var pamux_pkg::pamux_pins_s pin_in
);
    import pamux_pkg::*;
    // ========================================
    // A driving port wins the wire; otherwise the board sets it.
    assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule
`default_nettype wire

// >>> bench/test_pamux_port_low.sv
// Self-checking bench for the low-pin function mux.
// Assumes the design, the checker and the board model compile first.
`default_nettype none
module test_pamux_port_low;
    timeunit 1ns;
    timeprecision 1ns;
    import pamux_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp;
    pamux_pins_s pin_in, pin_out, pin_oe;
    pamux_pins_s ext = 5'h00;
    pamux_periph_s periph = 2'h0;
    pamux_route_s route;
    logic [4:0] lat = 5'h00;
    logic [4:0] dir = 5'h1F;
    logic [3:0] ans = 4'hF;
    logic [2:0] ctl = 3'h0;
    logic [4:0] eoe, eout, ein;
    logic [10:0] er;
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;
    pamux_port_low dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .periph(periph),
        .route(route));
    pamux_board u_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext),
        .pin_in(pin_in));
    initial forever #5 hclk = ~hclk;
    // ========================================
    // Checking and closing
    task automatic finish_test();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            finish_test();
        end
    end
    // ========================================
    // One AHB-Lite single word; read data lands in rd.
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    // ========================================
    // Reference model of the pins, routes and registers.
    task automatic check_all();
        logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h1C};
        logic [31:0] rv [5];
        logic [3:0] r;
        r = dir[3:0] & ans;
        eoe = ~dir & {2'h3, ~ctl[0], 2'h3};
        eout = {ctl[2] ? periph.sr_latch_true_output :
            ctl[1] ? periph.capture_compare_unit_five : lat[4], lat[3:0]};
        ein = ((eout & eoe) | (ext & ~eoe)) & ~{1'h0, ans} &
            ~{2'h0, ctl[0], 2'h0};
        er = {r[0], r[1], r[2], r[3], r[0], r[1], r[2], r[3], r[2], r[3],
            ctl[0] & ans[2]};
        rv = '{32'(lat), 32'(dir), 32'(ans), 32'(ctl), 32'h0};
        chk(32'(pin_oe), 32'(eoe));
        chk(32'(pin_out & eoe), 32'(eout & eoe));
        chk(32'(route), 32'(er));
        bus(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'(ein));
        bus(1'b0, 8'h14, 32'h0);
        chk(rd, 32'(er));
        foreach (ra[i]) begin
            bus(1'b0, ra[i], 32'h0);
            chk(rd, rv[i]);
        end
    endtask
    // ========================================
    // Main sequence: reset state first, then every control mode.
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        void'($urandom(32'h25CB));
        for (int i = 0; i < 48; i++) begin
            check_all();
            lat = 5'($urandom);
            dir = 5'($urandom);
            ans = 4'($urandom);
            ctl = 3'(i);
            ext <= 5'($urandom);
            periph <= 2'($urandom);
            bus(1'b1, 8'h00, 32'(lat));
            bus(1'b1, 8'h04, 32'(dir));
            bus(1'b1, 8'h08, 32'(ans));
            bus(1'b1, 8'h10, 32'(ctl));
            bus(1'b1, 8'h1C, $urandom);
            repeat (4) @(posedge hclk);
        end
        check_all();
        finish_test();
    end
endmodule
`default_nettype wire
